// >>> tbp_fwt.sv
// frame waiting timeout counter
`timescale 1ns/1ps
module tbp_fwt #(
  parameter int unsigned CYCLES = 16
) (
  input  logic clk_sys,  // system clock
  input  logic srst,     // synchronous reset
  input  logic run,      // count while waiting for an answer
  output logic expired   // level, high once the wait is used up
);

  localparam int unsigned CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LIMIT = CW'(CYCLES - 1);

  logic [CW-1:0] cnt;

  always_ff @(posedge clk_sys) begin
    if (srst || !run) begin
      cnt     <= '0;
      expired <= 1'b0;
    end else if (cnt == LIMIT) begin
      expired <= 1'b1;
    end else begin
      cnt <= cnt + CW'(1);
    end
  end

endmodule

// >>> tbp_host.sv
// reader-side block protocol engine: sends I, R and S blocks, tracks block number
// Behaviour
// - every block is an information, receipt (ACK/NAK) or supervisory block
// - no card identifier or node address byte in any frame
// - chaining both ways; each divided frame is at least 64 bytes
// - reader block number goes to 0 at every activation
// - reader toggles its number on I or ACK carrying its own number
// - reader always sends the first block; tag only responds
// - chained I block is answered with an ACK receipt block
// - illegal block or timeout gives NAK, except tag chaining or deselect
// - illegal block or timeout during tag chaining gives ACK
// - ACK with number unlike the reader's: resend last I block
// - ACK with the reader's number: go on with next chained block
// - failed DESELECT answer: repeat DESELECT or give up on the tag
// - data field at most 256 bytes including control byte and CRC
`timescale 1ns/1ps
module tbp_host
  import tbp_pkg::*;
#(
  parameter int unsigned FWT_CYCLES = FWT_CYC
) (
  input  logic       clk_sys,        // 50 MHz system clock
  input  logic       srst,           // synchronous reset, active high
  input  logic       activate,       // pulse: tag has just been activated
  output logic       active,         // tag currently addressed
  output logic       bn,             // reader block number
  input  logic       cmd_valid,      // command offered
  input  tbp_cmd_t   cmd,            // command: deselect or I block
  output logic       cmd_ready,      // command can be taken
  output logic       done_valid,     // pulse: exchange finished
  output tbp_res_t   done_res,       // outcome of the exchange
  input  logic       user_tx_valid,  // payload byte offered
  input  logic [7:0] user_tx_data,   // payload byte
  output logic       user_tx_ready,  // payload byte taken this cycle
  output logic       user_rewind,    // pulse: replay current payload from start
  output logic       user_rx_valid,  // pulse: received payload byte
  output logic [7:0] user_rx_data,   // received payload byte
  output logic       user_rx_last,   // last payload byte of the block
  output logic       link_tx_valid,  // byte to tag valid
  output logic [7:0] link_tx_data,   // byte to tag
  output logic       link_tx_last,   // last byte of frame
  input  logic       link_tx_ready,  // framer takes byte
  input  logic       link_rx_valid,  // byte from tag
  input  logic [7:0] link_rx_data,   // byte from tag
  input  logic       link_rx_last,   // last byte of frame
  input  logic       link_rx_err     // frame error such as CRC, with last
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  tbp_state_t       state;
  tbp_txk_t         tx_kind;
  logic             cur_chain;
  logic [LEN_W-1:0] cur_len;
  logic [LEN_W-1:0] tx_cnt;
  logic [LEN_W-1:0] rx_cnt;
  logic [7:0]       rx_pcb;
  logic             rx_bad;
  logic             tag_chain;
  logic             i_open;
  logic [1:0]       err_tries;
  logic [1:0]       dsel_tries;
  logic             tx_is_pcb;
  tbp_pcb_t         dec;
  logic             fwt_exp;

  tbp_pcb_dec u_dec (
    .pcb  (rx_pcb),
    .info (dec)
  );

  tbp_fwt #(.CYCLES(FWT_CYCLES)) u_fwt (
    .clk_sys (clk_sys),
    .srst    (srst),
    .run     (state == S_WAIT),
    .expired (fwt_exp)
  );

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire slot_free  = !link_tx_valid || link_tx_ready;
  wire take_cmd   = cmd_valid && cmd_ready;
  wire take_byte  = user_tx_valid && user_tx_ready;
  wire len_bad    = !cmd.dsel && ((cmd.chain && cmd.len < LEN_W'(CHAIN_INF_MIN))
                    || cmd.len > LEN_W'(INF_MAX));
  wire sent_dsel  = tx_kind == TX_DSEL;
  wire in_eval    = state == S_EVAL;
  wire rx_ok      = !rx_bad && dec.legal;
  wire bn_eq      = dec.bn == bn;
  wire ev_dsel_ok = rx_ok && dec.is_dsel;
  wire ev_i       = rx_ok && dec.is_i && bn_eq && !(i_open && cur_chain);
  wire ev_more    = rx_ok && dec.is_ack && bn_eq && i_open && cur_chain;
  wire ev_retx    = rx_ok && dec.is_ack && !bn_eq && i_open;
  wire ev_bad     = !(ev_i || ev_more || ev_retx);
  wire retry_out  = err_tries == RETRY_MAX;
  wire inf_last   = tx_cnt + LEN_W'(1) == cur_len;
  wire rx_ovf     = rx_cnt == LEN_W'(INF_MAX);
  wire pcb_last   = tx_kind != TX_I || cur_len == '0;

  logic [7:0] tx_pcb;
  always_comb begin
    case (tx_kind)
      TX_I:    tx_pcb = PCB_I | {3'h0, cur_chain, 3'h0, bn};
      TX_ACK:  tx_pcb = PCB_R_ACK | {7'h00, bn};
      TX_NAK:  tx_pcb = PCB_R_NAK | {7'h00, bn};
      default: tx_pcb = PCB_S_DSEL;
    endcase
  end

  // ----------------------------------------------------------------
  // link transmit and payload handshake
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (srst || activate) begin
      link_tx_valid <= 1'b0;
      link_tx_data  <= 8'h00;
      link_tx_last  <= 1'b0;
      tx_is_pcb     <= 1'b0;
      user_tx_ready <= 1'b0;
    end else begin
      user_tx_ready <= state == S_INF && !take_byte && slot_free;
      if (state == S_PCB && slot_free) begin
        link_tx_valid <= 1'b1;
        link_tx_data  <= tx_pcb;
        link_tx_last  <= pcb_last;
        tx_is_pcb     <= 1'b1;
      end else if (take_byte) begin
        link_tx_valid <= 1'b1;
        link_tx_data  <= user_tx_data;
        link_tx_last  <= inf_last;
        tx_is_pcb     <= 1'b0;
      end else if (link_tx_ready) begin
        link_tx_valid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // receive path
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      user_rx_valid <= 1'b0;
      user_rx_data  <= 8'h00;
      user_rx_last  <= 1'b0;
    end else begin
      user_rx_valid <= state == S_RECV && link_rx_valid && dec.is_i && !rx_ovf;
      user_rx_data  <= link_rx_data;
      user_rx_last  <= link_rx_last;
    end
  end

  // ----------------------------------------------------------------
  // protocol sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state      <= S_IDLE;
      active     <= 1'b0;
      bn         <= 1'b0;
      tx_kind    <= TX_I;
      cur_chain  <= 1'b0;
      cur_len    <= '0;
      tx_cnt     <= '0;
      rx_cnt     <= '0;
      rx_pcb     <= 8'h00;
      rx_bad     <= 1'b0;
      tag_chain  <= 1'b0;
      i_open     <= 1'b0;
      err_tries  <= '0;
      dsel_tries <= '0;
      cmd_ready  <= 1'b0;
      done_valid <= 1'b0;
      done_res   <= '0;
      user_rewind <= 1'b0;
    end else if (activate) begin
      state     <= S_IDLE;
      active    <= 1'b1;
      bn        <= 1'b0;
      tag_chain <= 1'b0;
      i_open    <= 1'b0;
      err_tries <= '0;
      cmd_ready <= 1'b1;
      done_valid <= 1'b0;
      user_rewind <= 1'b0;
    end else begin
      done_valid  <= 1'b0;
      user_rewind <= 1'b0;
      cmd_ready   <= 1'b0;
      case (state)
        S_IDLE: begin
          cmd_ready <= active && !take_cmd;
          if (take_cmd) begin
            cur_chain  <= cmd.chain;
            cur_len    <= cmd.len;
            dsel_tries <= '0;
            err_tries  <= '0;
            tx_kind    <= cmd.dsel ? TX_DSEL : TX_I;
            if (len_bad) begin
              done_valid <= 1'b1;
              done_res   <= '{refused: 1'b1, default: 1'b0};
              cmd_ready  <= 1'b1;
            end else begin
              state <= S_PCB;
            end
          end
        end
        S_PCB: begin
          if (slot_free) begin
            tx_cnt <= '0;
            if (tx_kind == TX_I) begin
              i_open <= 1'b1;
            end
            state <= pcb_last ? S_WAIT : S_INF;
          end
        end
        S_INF: begin
          if (take_byte) begin
            tx_cnt <= tx_cnt + LEN_W'(1);
            if (inf_last) begin
              state <= S_WAIT;
            end
          end
        end
        S_WAIT: begin
          rx_cnt <= '0;
          if (link_rx_valid) begin
            rx_pcb <= link_rx_data;
            rx_bad <= link_rx_last && link_rx_err;
            state  <= link_rx_last ? S_EVAL : S_RECV;
          end else if (fwt_exp) begin
            rx_bad <= 1'b1;
            state  <= S_EVAL;
          end
        end
        S_RECV: begin
          if (link_rx_valid) begin
            rx_cnt <= rx_cnt + LEN_W'(1);
            if (rx_ovf || (link_rx_last && link_rx_err)) begin
              rx_bad <= 1'b1;
            end
            if (link_rx_last) begin
              state <= S_EVAL;
            end
          end
        end
        S_EVAL: begin
          state <= S_PCB;
          if (sent_dsel) begin
            if (ev_dsel_ok) begin
              active     <= 1'b0;
              done_valid <= 1'b1;
              done_res   <= '{deselected: 1'b1, default: 1'b0};
              state      <= S_IDLE;
            end else if (dsel_tries == RETRY_MAX) begin
              active     <= 1'b0;
              done_valid <= 1'b1;
              done_res   <= '{gave_up: 1'b1, default: 1'b0};
              state      <= S_IDLE;
            end else begin
              dsel_tries <= dsel_tries + 2'h1;
            end
          end else if (ev_i) begin
            bn        <= ~bn;
            err_tries <= '0;
            i_open    <= 1'b0;
            tag_chain <= dec.chain;
            if (dec.chain) begin
              tx_kind <= TX_ACK;
            end else begin
              done_valid <= 1'b1;
              done_res   <= '{ok: 1'b1, default: 1'b0};
              cmd_ready  <= 1'b1;
              state      <= S_IDLE;
            end
          end else if (ev_more) begin
            bn         <= ~bn;
            i_open     <= 1'b0;
            err_tries  <= '0;
            done_valid <= 1'b1;
            done_res   <= '{more: 1'b1, default: 1'b0};
            cmd_ready  <= 1'b1;
            state      <= S_IDLE;
          end else if (retry_out) begin
            active     <= 1'b0;
            done_valid <= 1'b1;
            done_res   <= '{gave_up: 1'b1, default: 1'b0};
            state      <= S_IDLE;
          end else if (ev_retx) begin
            err_tries   <= err_tries + 2'h1;
            tx_kind     <= TX_I;
            user_rewind <= 1'b1;
          end else begin
            err_tries <= err_tries + 2'h1;
            tx_kind   <= tag_chain ? TX_ACK : TX_NAK;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  a_act_bn_zero: assert property (activate |=> bn == 1'b0 && state == S_IDLE)
    else $error("block number not zero after activation");
  a_pcb_no_cid: assert property (link_tx_valid && tx_is_pcb |->
      !link_tx_data[PCB_CID_POS]) else $error("identifier bit set in control byte");
  a_host_first: assert property (!active && !activate |=> !link_tx_valid)
    else $error("frame sent while tag not addressed");
  a_i_toggle: assert property (in_eval && !sent_dsel && ev_i && !activate
      |=> bn != $past(bn)) else $error("block number not toggled on I block");
  a_chain_ack: assert property (in_eval && !sent_dsel && ev_i && dec.chain
      && !activate |=> state == S_PCB ##1 link_tx_valid && link_tx_data == (PCB_R_ACK | {7'h00, bn}))
    else $error("chained I block not acknowledged");
  a_err_nak: assert property (in_eval && !sent_dsel && ev_bad && !retry_out
      && !tag_chain && !activate |=> tx_kind == TX_NAK && state == S_PCB)
    else $error("error not answered by NAK");
  a_err_ack: assert property (in_eval && !sent_dsel && ev_bad && !retry_out
      && tag_chain && !activate |=> tx_kind == TX_ACK && state == S_PCB)
    else $error("error during tag chain not answered by ACK");
  a_retx_last: assert property (in_eval && !sent_dsel && ev_retx && !retry_out
      && !activate |=> user_rewind && tx_kind == TX_I && bn == $past(bn))
    else $error("no resend on ACK with other number");
  a_more_next: assert property (in_eval && !sent_dsel && ev_more && !activate
      |=> done_valid && done_res.more && cmd_ready)
    else $error("chain not continued on matching ACK");
  a_dsel_retry: assert property (in_eval && sent_dsel && !ev_dsel_ok
      && !activate |=> (state == S_PCB && tx_kind == TX_DSEL) || (done_valid && !active))
    else $error("failed deselect neither repeated nor abandoned");
  a_len_refuse: assert property (take_cmd && len_bad && !activate
      |=> done_valid && done_res.refused && state == S_IDLE)
    else $error("bad block length not refused");

  c_tag_chain: cover property (in_eval && ev_i && dec.chain ##[1:20] state == S_WAIT);
  c_deselect:  cover property (in_eval && sent_dsel && ev_dsel_ok);
  c_resend:    cover property (in_eval && !sent_dsel && ev_retx);
  c_timeout:   cover property (state == S_WAIT && fwt_exp);

endmodule

// >>> tbp_host_test.sv
// self-checking bench for the reader-side block protocol engine
`timescale 1ns/1ps
module tbp_host_test;
  import tbp_pkg::*;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic       clk_sys, srst, activate, active, bn, cmd_valid, cmd_ready;
  logic       done_valid, user_tx_valid, user_tx_ready, user_rewind, mute;
  logic       user_rx_valid, user_rx_last, link_tx_valid, link_tx_last;
  logic       link_tx_ready, link_rx_valid, link_rx_last, link_rx_err;
  logic [7:0] user_tx_data, user_rx_data, link_tx_data, link_rx_data, gap, rxl;
  logic [7:0] hp[$];
  tbp_cmd_t   cmd;
  tbp_res_t   done_res, dres;
  int         nf, fl, tn, rxn, rw, ti, cyc, err_total, checks_done;
  tbp_host #(.FWT_CYCLES(50)) dut (.clk_sys(clk_sys), .srst(srst), .activate(activate),
    .active(active), .bn(bn), .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready),
    .done_valid(done_valid), .done_res(done_res), .user_tx_valid(user_tx_valid),
    .user_tx_data(user_tx_data), .user_tx_ready(user_tx_ready), .user_rewind(user_rewind),
    .user_rx_valid(user_rx_valid), .user_rx_data(user_rx_data), .user_rx_last(user_rx_last),
    .link_tx_valid(link_tx_valid), .link_tx_data(link_tx_data), .link_tx_last(link_tx_last),
    .link_tx_ready(link_tx_ready), .link_rx_valid(link_rx_valid),
    .link_rx_data(link_rx_data), .link_rx_last(link_rx_last), .link_rx_err(link_rx_err));
  tbp_tag_model tag (.clk_sys(clk_sys), .srst(srst), .activate(activate), .mute(mute),
    .gap(gap), .link_tx_valid(link_tx_valid), .link_tx_data(link_tx_data),
    .link_tx_last(link_tx_last), .link_tx_ready(link_tx_ready),
    .link_rx_valid(link_rx_valid), .link_rx_data(link_rx_data),
    .link_rx_last(link_rx_last), .link_rx_err(link_rx_err));
  // ----------------------------------------------------------------
  // monitors and payload source
  // ----------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (link_tx_valid && link_tx_ready) begin
      if (tn == 0) hp.push_back(link_tx_data);
      tn++;
      if (link_tx_last) begin
        fl = tn;
        tn = 0;
        nf++;
      end
    end
    if (user_rx_valid) rxn++;
    if (user_rx_valid && user_rx_last) rxl = user_rx_data;
    if (user_rewind) rw++;
    if (user_rewind) ti = 0;
    else if (user_tx_valid && user_tx_ready) ti++;
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      $display("[FAIL] %0t run hung", $time);
      report_and_stop();
    end
  end
  always @(negedge clk_sys) user_tx_data <= 8'(ti);
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic report_and_stop;
    if (err_total == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic run_cmd(input logic dsel, input logic chain, input int len);
    @(negedge clk_sys);
    hp = {};
    {rxn, rw, nf, ti} = '0;
    cmd_valid = 1'b1;
    cmd = '{dsel, chain, 9'(len)};
    do @(posedge clk_sys); while (cmd_ready !== 1'b1);
    @(negedge clk_sys);
    cmd_valid = 1'b0;
    do @(posedge clk_sys); while (done_valid !== 1'b1);
    dres = done_res;
    @(negedge clk_sys);
  endtask
  task automatic activate_tag;
    @(negedge clk_sys);
    activate = 1'b1;
    @(negedge clk_sys);
    activate = 1'b0;
    chk(8'(active), 8'h01, "active");
    chk(8'(bn), 8'h00, "bn start");
  endtask
  task automatic t_plain;
    run_cmd(1'b0, 1'b0, 2);
    chk(hp[0], PCB_I, "i pcb");
    chk(8'(fl), 8'h03, "frame len");
    chk(8'(dres), 8'h01, "ok");
    chk(8'(rxn), 8'h02, "rx bytes");
    chk(rxl, 8'hA5, "rx data");
    chk(8'(bn), 8'h01, "bn toggled");
  endtask
  task automatic t_chain;
    run_cmd(1'b0, 1'b1, 60);
    chk(8'(dres), 8'h10, "short chain");
    run_cmd(1'b0, 1'b0, 254);
    chk(8'(dres), 8'h10, "long frame");
    run_cmd(1'b0, 1'b1, 61);
    chk(hp[0], 8'h13, "chain pcb");
    chk(8'(fl), 8'h3E, "chain len");
    chk(8'(dres), 8'h02, "more");
    chk(8'(bn), 8'h00, "bn chain");
    gap = 8'h14;
    run_cmd(1'b0, 1'b0, 253);
    gap = 8'h00;
    chk(8'(fl), 8'hFE, "max len");
    chk(8'(dres), 8'h01, "max ok");
  endtask
  task automatic t_timeout;
    mute = 1'b1;
    nf = 0;
    fork
      run_cmd(1'b0, 1'b0, 3);
      begin
        wait (nf == 1);
        @(negedge clk_sys);
        mute = 1'b0;
      end
    join
    chk(hp[1], 8'hB3, "nak");
    chk(hp[2], 8'h03, "resend");
    chk(8'(rw), 8'h01, "rewind");
    chk(8'(fl), 8'h04, "resend len");
    chk(8'(dres), 8'h01, "retry ok");
  endtask
  task automatic t_tag_chain;
    fork
      run_cmd(1'b0, 1'b0, 4);
      begin
        wait (nf == 1);
        @(negedge clk_sys);
        mute = 1'b1;
        wait (nf == 2);
        @(negedge clk_sys);
        mute = 1'b0;
      end
    join
    chk(hp[0], PCB_I, "chain trigger");
    chk(hp[1], 8'hA3, "tag chain ack");
    chk(hp[2], 8'hA3, "ack on timeout");
    chk(8'(hp.size()), 8'h03, "chain frames");
    chk(8'(rxn), 8'h7A, "chain rx bytes");
    chk(rxl, 8'h3C, "chain rx data");
    chk(8'(dres), 8'h01, "chain done");
    chk(8'(bn), 8'h00, "bn after chain");
  endtask
  task automatic t_dsel;
    run_cmd(1'b1, 1'b0, 0);
    chk(hp[0], PCB_S_DSEL, "dsel pcb");
    chk(8'(dres), 8'h04, "deselected");
    chk(8'(active), 8'h00, "inactive");
    activate_tag();
    mute = 1'b1;
    run_cmd(1'b1, 1'b0, 0);
    mute = 1'b0;
    chk(8'(dres), 8'h08, "gave up");
    chk(8'(hp.size() > 1), 8'h01, "repeat");
    chk(hp[hp.size() - 1], PCB_S_DSEL, "repeat pcb");
    chk(8'(active), 8'h00, "dropped");
  endtask
  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  initial begin
    {srst, activate, cmd_valid, user_tx_valid, mute, gap, user_tx_data} = 21'h10_0000;
    cmd = '0;
    hp = {};
    {nf, fl, tn, rxn, rw, ti, cyc, err_total, checks_done} = '0;
    repeat (5) @(negedge clk_sys);
    srst = 1'b0;
    chk(8'(cmd_ready), 8'h00, "idle after reset");
    user_tx_valid = 1'b1;
    activate_tag();
    t_plain();
    t_chain();
    t_timeout();
    t_tag_chain();
    t_dsel();
    activate_tag();
    report_and_stop();
  end
endmodule

// >>> tbp_pcb_dec.sv
// classifies a received protocol control byte
`timescale 1ns/1ps
module tbp_pcb_dec
  import tbp_pkg::*;
(
  input  logic [7:0] pcb,   // received control byte
  output tbp_pcb_t   info   // decoded block type and fields
);

  wire i_blk   = (pcb & PCB_TYPE_MASK) == PCB_I;
  wire r_blk   = (pcb & PCB_TYPE_MASK) == PCB_R_ACK;
  wire s_dsel  = pcb == PCB_S_DSEL;

  assign info.is_i    = i_blk;
  assign info.is_ack  = r_blk & ~pcb[PCB_NAK_POS];
  assign info.is_nak  = r_blk & pcb[PCB_NAK_POS];
  assign info.is_dsel = s_dsel;
  assign info.chain   = i_blk & pcb[PCB_CHAIN_POS];
  assign info.bn      = pcb[PCB_BN_POS];
  // identifier bit set, or any other type such as wait extension, is illegal
  assign info.legal   = (i_blk | r_blk | s_dsel) & ~pcb[PCB_CID_POS];

endmodule

// >>> tbp_pkg.sv
// constants and types for the block protocol controller on the reader side
package tbp_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_NS      = 20;
  localparam int unsigned FWT_BASE_NS = 302_000;
  localparam int unsigned FWI_DEFAULT = 4;
  localparam int unsigned FWT_CYC     = (FWT_BASE_NS << FWI_DEFAULT) / CLK_NS;

  // ----------------------------------------------------------------
  // frame sizes
  // ----------------------------------------------------------------
  localparam int unsigned LEN_W         = 9;
  localparam int unsigned FRAME_MAX     = 256;
  localparam int unsigned FRAME_OVH     = 3;
  localparam int unsigned CHAIN_MIN     = 64;
  localparam int unsigned INF_MAX       = FRAME_MAX - FRAME_OVH;
  localparam int unsigned CHAIN_INF_MIN = CHAIN_MIN - FRAME_OVH;
  localparam logic [1:0]  RETRY_MAX     = 2'h3;

  // ----------------------------------------------------------------
  // protocol control byte
  // ----------------------------------------------------------------
  localparam logic [7:0] PCB_I         = 8'h02;
  localparam logic [7:0] PCB_R_ACK     = 8'hA2;
  localparam logic [7:0] PCB_R_NAK     = 8'hB2;
  localparam logic [7:0] PCB_S_DSEL    = 8'hC2;
  localparam logic [7:0] PCB_TYPE_MASK = 8'hEE;
  localparam int unsigned PCB_BN_POS    = 0;
  localparam int unsigned PCB_CID_POS   = 3;
  localparam int unsigned PCB_CHAIN_POS = 4;
  localparam int unsigned PCB_NAK_POS   = 4;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_PCB  = 3'b001,
    S_INF  = 3'b010,
    S_WAIT = 3'b011,
    S_RECV = 3'b100,
    S_EVAL = 3'b101
  } tbp_state_t;

  typedef enum logic [1:0] {
    TX_I    = 2'b00,
    TX_ACK  = 2'b01,
    TX_NAK  = 2'b10,
    TX_DSEL = 2'b11
  } tbp_txk_t;

  typedef struct packed {
    logic             dsel;
    logic             chain;
    logic [LEN_W-1:0] len;
  } tbp_cmd_t;

  typedef struct packed {
    logic refused;
    logic gave_up;
    logic deselected;
    logic more;
    logic ok;
  } tbp_res_t;

  typedef struct packed {
    logic is_i;
    logic is_ack;
    logic is_nak;
    logic is_dsel;
    logic chain;
    logic bn;
    logic legal;
  } tbp_pcb_t;

endpackage

// >>> tbp_tag_model.sv
// tag-side model: answers reader frames by the block rules
`timescale 1ns/1ps
module tbp_tag_model
  import tbp_pkg::*;
(
  input  wire logic       clk_sys,       // clock
  input  wire logic       srst,          // reset
  input  wire logic       activate,      // tag activated
  input  wire logic       mute,          // drop frames
  input  wire logic [7:0] gap,           // extra reply delay
  input  wire logic       link_tx_valid, // reader byte
  input  wire logic [7:0] link_tx_data,  // reader data
  input  wire logic       link_tx_last,  // reader last
  output logic            link_tx_ready, // always taken
  output logic            link_rx_valid, // reply byte
  output logic [7:0]      link_rx_data,  // reply data
  output logic            link_rx_last,  // reply last
  output logic            link_rx_err    // never set
);
  logic [7:0] p, b, out[$], last_i[$];
  logic       tbn;
  int         n, w, f;
  assign link_tx_ready = 1'b1;
  assign link_rx_err   = 1'b0;
  initial {link_rx_valid, link_rx_last, link_rx_data} = '0;
  always @(posedge clk_sys) begin
    link_rx_valid <= 1'b0;
    link_rx_last  <= 1'b0;
    link_rx_data  <= ~link_rx_data;
    if (srst || activate) begin
      tbn = 1'b1;
      n = 0;
      w = 0;
      out = {};
    end else begin
      if (link_tx_valid) begin
        p = (n == 0) ? link_tx_data : p;
        f = n + 1;
        n = link_tx_last ? 0 : n + 1;
        if (link_tx_last && !mute) begin
          w = gap + 2;
          if (p[7:6] == 2'b00) begin
            tbn = ~tbn;
            if (p[PCB_CHAIN_POS]) out = {PCB_R_ACK | tbn};
            else if (f == 5) begin
              // five-byte frame asks for a chained answer of minimum size
              last_i = {PCB_I | 8'h10 | tbn};
              repeat (61) last_i.push_back(8'h3C);
              out = last_i;
            end else begin
              last_i = {PCB_I | tbn, 8'h5A, 8'hA5};
              out = last_i;
            end
          end else if (p[7:5] == 3'b101) begin
            if (p[0] == tbn) out = last_i;
            else if (p[PCB_NAK_POS]) out = {PCB_R_ACK | tbn};
            else begin
              tbn = ~tbn;
              last_i[0][0] = tbn;
              last_i[0][PCB_CHAIN_POS] = 1'b0;
              out = last_i;
            end
          end else if (p == PCB_S_DSEL) out = {PCB_S_DSEL};
        end
      end
      if (w > 0) w--;
      else if (out.size() > 0) begin
        b = out.pop_front();
        link_rx_valid <= 1'b1;
        link_rx_data  <= b;
        link_rx_last  <= (out.size() == 0);
      end
    end
  end
endmodule
